// ==== random_fruit_parameter_gen_test.sv ====
// self-checking bench for the random fruit parameter generator
`timescale 1ns/1ns
module random_fruit_parameter_gen_test;
    reg         sys_clk, rst, param_load, group_req, e_valid, e_fixed, e_beam, e_sign, fx;
    reg  [4:0]  fixed_code_fraction_in, p_frac;
    reg  [11:0] fixed_code_in, p_fixed, e_code;
    reg  [15:0] e_pul, m_cnt;
    reg  [10:0] e_ang;
    reg  [5:0]  e_pow;
    reg  [31:0] rnd, m_code, m_frac, m_pow, m_ang, m_beam;
    wire        group_valid, beam_select, sidelobe_atten_en, angle_sign, code_is_fixed;
    wire [5:0]  power_field;
    wire [10:0] angle_word;
    wire [11:0] reply_code;
    wire [15:0] reply_pulses, n_groups;
    integer     i, n_errors, n_tests;

    rfpg_top rfpg_top_inst (.sys_clk(sys_clk), .rst(rst), .param_load(param_load),
        .fixed_code_fraction_in(fixed_code_fraction_in), .fixed_code_in(fixed_code_in),
        .group_req(group_req), .group_valid(group_valid), .power_field(power_field),
        .beam_select(beam_select), .sidelobe_atten_en(sidelobe_atten_en), .angle_word(angle_word),
        .angle_sign(angle_sign), .reply_code(reply_code), .reply_pulses(reply_pulses),
        .code_is_fixed(code_is_fixed));
    rfpg_collector rfpg_collector_inst (.sys_clk(sys_clk), .rst(rst), .group_valid(group_valid),
        .n_groups(n_groups));

    function [31:0] step_f(input [31:0] s, input integer n, input integer t);
        step_f = ((s << 1) | (((s >> (n - 1)) ^ (s >> (t - 1))) & 32'h1)) & ((32'h1 << n) - 32'h1);
    endfunction
    function [31:0] lfsr_f(input [31:0] x);
        lfsr_f = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function [5:0] cd_f(input [8:0] a);
        reg [8:0] k;
        begin
            k = (a - 9'h156) % 9'h005;
            if (a < 9'h156)
                cd_f = a[5:0];
            else
                cd_f = {(k == 9'h004) ? 3'h6 : k[2:0] + 3'h1, (a < 9'h16f) ? 3'h4 : 3'h0};
        end
    endfunction
    // rounded entries per attenuation step in each rom half
    function integer cnt_f(input s, input integer l);
        cnt_f = s ? (l == 0 ? 0 : l < 4 ? 1 : l < 9 ? 2 : l < 12 ? 3 : l < 14 ? 4 : l < 16 ? 5 : l == 16 ? 6 :
                     l == 17 ? 7 : l < 20 ? 8 : l == 20 ? 10 : l == 21 ? 11 : l == 22 ? 12 : l == 23 ? 13 :
                     l == 24 ? 15 : l == 25 ? 17 : l == 26 ? 19 : l == 27 ? 21 : l == 28 ? 24 : l == 29 ? 27 :
                     l == 30 ? 18 : 0)
                  : (l < 5 ? 0 : l < 15 ? 1 : l < 19 ? 2 : l < 22 ? 3 : l < 24 ? 4 : l < 26 ? 5 : l == 26 ? 6 :
                     l == 27 ? 7 : l < 30 ? 8 : l == 30 ? 9 : l == 31 ? 11 : l == 32 ? 12 : l == 33 ? 13 :
                     l == 34 ? 15 : l == 35 ? 17 : l == 36 ? 19 : l == 37 ? 21 : l == 38 ? 24 : l == 39 ? 27 :
                     l == 40 ? 14 : 0);
    endfunction
    function [5:0] pow_f(input [8:0] a);
        integer l, acc, c;
        begin
            pow_f = 6'h00;
            acc = 0;
            for (l = 0; l < 41; l = l + 1) begin
                c = cnt_f(a[8], l);
                if (a[7:0] >= acc && a[7:0] < acc + c)
                    pow_f = l;
                acc = acc + c;
            end
        end
    endfunction
    function [15:0] pul_f(input [11:0] c);
        pul_f = {1'b1, c[3], c[9], c[4], c[10], c[5], c[11], 1'b0, c[6], c[0], c[7], c[1], c[8], c[2], 2'b10};
    endfunction

    task check(input [31:0] seen, input [31:0] want);
        begin
            n_tests = n_tests + 1;
            if (seen !== want) begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // reference state, same edge sampling as the design
    always @(posedge sys_clk) begin
        e_valid = 1'b0;
        if (rst) begin
            {e_code, e_fixed, e_beam, e_ang, e_sign, e_pul, p_frac, p_fixed, m_cnt, e_pow} = 0;
            m_code = 32'h7000;
            m_frac = 32'h70;
            m_pow  = 32'h7000;
            m_ang  = 32'h700;
            m_beam = 32'h1c000;
        end else begin
            if (group_req) begin
                fx      = p_frac[4] | (m_frac[3:0] < p_frac[3:0]);
                e_code  = fx ? p_fixed : {m_code[5:0], cd_f(m_code[14:6])};
                {e_valid, e_fixed, e_beam, e_ang, e_sign} = {1'b1, fx, m_beam[0], m_ang[10:0], m_pow[14]};
                e_pul   = pul_f(e_code);
                e_pow   = pow_f({m_beam[0], m_pow[7:0]});
                m_cnt   = m_cnt + 16'h0001;
                m_code  = step_f(m_code, 15, 14);
                m_frac  = step_f(m_frac, 7, 6);
                m_pow   = step_f(m_pow, 15, 14);
                m_ang   = step_f(m_ang, 11, 9);
                m_beam  = step_f(m_beam, 17, 14);
            end
            if (param_load)
                {p_frac, p_fixed} = {fixed_code_fraction_in, fixed_code_in};
        end
    end

    always @(negedge sys_clk) begin
        if (!rst) begin
            check(group_valid, e_valid);
            check(reply_code, e_code);
            check({code_is_fixed, beam_select, sidelobe_atten_en}, {e_fixed, e_beam, e_beam});
            check({angle_word, angle_sign}, {e_ang, e_sign});
            check(reply_pulses, e_pul);
            check(power_field <= (e_beam ? 6'h1e : 6'h28), 1);
            check(power_field, e_pow);
        end
    end

    initial begin
        {rst, param_load, group_req, fixed_code_fraction_in, fixed_code_in} = {1'b1, 19'h0_0000};
        {n_errors, n_tests} = 0;
        rnd = 32'h1b03;
        repeat (10) @(posedge sys_clk);
        for (i = 0; i < 3000; i = i + 1) begin
            rnd = lfsr_f(rnd);
            rst <= (i >= 1500 && i < 1502);
            group_req <= i < 10 || rnd[0] | rnd[1];
            // loads keep the fraction in corner bands first, then random incl. above sixteen
            param_load <= rnd[6:2] == 5'h00 || (i > 2800 && rnd[3]);
            fixed_code_fraction_in <= (i < 500) ? 5'h00 : (i < 1000) ? 5'h10 : (i < 1500) ? 5'h1f : rnd[12:8];
            fixed_code_in <= rnd[24:13];
            @(posedge sys_clk);
        end
        group_req <= 1'b0;
        param_load <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check(n_groups, m_cnt);
        print_verdict;
    end
endmodule // random_fruit_parameter_gen_test

// ==== rfpg_cd_rom.v ====
// conversion table from nine generator bits to the c and d code bits
`timescale 1ns/1ns
`include "rfpg_defines.vh"

module rfpg_cd_rom (
    // lookup address
    input  wire [8:0] addr,
    // c bits in [5:3], d bits in [2:0]
    output reg  [5:0] cd
);

    reg [8:0] offset;
    reg [8:0] phase;
    reg [2:0] c_val;

    always @* begin
        offset = 9'h0_000;
        phase  = 9'h0_000;
        c_val  = 3'h0;
        if (addr < `RFPG_CD_UNIFORM) begin
            // counting through all 64 combinations
            cd = addr[5:0];
        end else begin
            offset = addr - `RFPG_CD_UNIFORM;
            phase  = offset % 9'h0_005;
            case (phase[2:0])
                3'h0:    c_val = 3'h1;
                3'h1:    c_val = 3'h2;
                3'h2:    c_val = 3'h3;
                3'h3:    c_val = 3'h4;
                default: c_val = 3'h6;
            endcase
            if (offset < `RFPG_CD_D4_COUNT) begin
                cd = {c_val, `RFPG_D4_ONLY};
            end else begin
                cd = {c_val, 3'h0};
            end
        end
    end

endmodule // rfpg_cd_rom

// ==== rfpg_checker.sv ====
// port assertions for the random fruit parameter generator
`timescale 1ns/1ns
module rfpg_checker (
    // clock and reset
    input wire        sys_clk,
    input wire        rst,
    // controller side
    input wire        param_load,
    input wire [4:0]  fixed_code_fraction_in,
    input wire [11:0] fixed_code_in,
    input wire        group_req,
    // group outputs
    input wire        group_valid,
    input wire [5:0]  power_field,
    input wire        beam_select,
    input wire        sidelobe_atten_en,
    input wire [11:0] reply_code,
    input wire [15:0] reply_pulses,
    input wire        code_is_fixed
);
    reg [4:0]  frac_q;
    reg [11:0] fixed_q;
    always @(posedge sys_clk) begin
        if (rst) begin
            frac_q  <= 5'h00;
            fixed_q <= 12'h000;
        end else if (param_load) begin
            frac_q  <= fixed_code_fraction_in;
            fixed_q <= fixed_code_in;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_valid_after_req: assert property (group_req |=> group_valid)
        else $error("no group after request");
    chk_valid_only_req: assert property (!group_req |=> !group_valid)
        else $error("group without request");
    chk_atten_follows: assert property (sidelobe_atten_en == beam_select)
        else $error("attenuation differs from beam bit");
    chk_framing_pulses: assert property (group_valid |-> reply_pulses[15] && reply_pulses[1] &&
        !reply_pulses[8] && !reply_pulses[0]) else $error("framing or x pulse wrong");
    chk_power_half: assert property (group_valid |-> power_field <= (beam_select ? 6'h1e : 6'h28))
        else $error("power out of range");
    chk_fields_hold: assert property (!group_valid && !$past(rst) |-> $stable(reply_code) &&
        $stable(power_field) && $stable(beam_select)) else $error("fields moved");
    chk_msb_fixed: assert property (group_req && frac_q[4] |=> code_is_fixed)
        else $error("msb did not force fixed");
    chk_zero_random: assert property (group_req && frac_q == 5'h00 |=> !code_is_fixed)
        else $error("zero fraction gave fixed");
    chk_fixed_value: assert property (group_valid && code_is_fixed |-> reply_code == $past(fixed_q))
        else $error("fixed code differs");
    cover property (group_valid && group_req);
    cover property (group_valid && code_is_fixed);
    cover property (group_valid && beam_select);
endmodule // rfpg_checker

bind rfpg_top rfpg_checker rfpg_checker_inst (
    .sys_clk(sys_clk), .rst(rst), .param_load(param_load),
    .fixed_code_fraction_in(fixed_code_fraction_in), .fixed_code_in(fixed_code_in),
    .group_req(group_req), .group_valid(group_valid), .power_field(power_field),
    .beam_select(beam_select), .sidelobe_atten_en(sidelobe_atten_en),
    .reply_code(reply_code), .reply_pulses(reply_pulses), .code_is_fixed(code_is_fixed)
);

// ==== rfpg_collector.sv ====
// fruit reply controller model that collects control word groups
`timescale 1ns/1ns
module rfpg_collector (
    // clock and reset
    input wire        sys_clk,
    input wire        rst,
    // group strobe
    input wire        group_valid,
    // groups taken since reset
    output reg [15:0] n_groups
);
    always @(posedge sys_clk) begin
        if (rst)
            n_groups <= 16'h0000;
        else if (group_valid)
            n_groups <= n_groups + 16'h0001;
    end
endmodule // rfpg_collector

// ==== rfpg_defines.vh ====
// constants shared by the random fruit parameter generator files
`ifndef RFPG_DEFINES_VH
`define RFPG_DEFINES_VH

// field widths
`define RFPG_POWER_W      6
`define RFPG_ANGLE_W      11
`define RFPG_CODE_W       12
`define RFPG_FRAC_W       5
`define RFPG_PULSE_W      16
`define RFPG_ROM_ADDR_W   9

// generator lengths and feedback stages (stage numbers, 1-based)
`define RFPG_CODE_LEN     15
`define RFPG_CODE_TAP     14
`define RFPG_FRAC_LEN     7
`define RFPG_FRAC_TAP     6
`define RFPG_POWER_LEN    15
`define RFPG_POWER_TAP    14
`define RFPG_ANGLE_LEN    11
`define RFPG_ANGLE_TAP    9
`define RFPG_BEAM_LEN     17
`define RFPG_BEAM_TAP     14

// conversion rom split
`define RFPG_CD_UNIFORM   9'h0_156
`define RFPG_CD_D4_COUNT  9'h0_019
`define RFPG_D4_ONLY      3'h4

// power rom halves
`define RFPG_HALF_DEPTH   256
`define RFPG_MAIN_LEVELS  41
`define RFPG_SIDE_LEVELS  31

// reset values
`define RFPG_FRAC_RST     5'h00
`define RFPG_FIXED_RST    12'h000

`endif

// ==== rfpg_lfsr.v ====
// maximal-length shift register generator with fixed reset pattern
`timescale 1ns/1ns
`include "rfpg_defines.vh"

module rfpg_lfsr #(
    parameter WIDTH = 7,
    parameter TAP   = 6
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             rst,
    // advance strobe
    input  wire             step,
    // generator state
    output reg  [WIDTH-1:0] state
);

    wire feedback;

    assign feedback = state[WIDTH-1] ^ state[TAP-1];

    // three ones then zeros: never the locked all-zero state
    always @(posedge sys_clk) begin
        if (rst) begin
            state <= {3'b111, {(WIDTH-3){1'b0}}};
        end else if (step) begin
            state <= {state[WIDTH-2:0], feedback};
        end
    end

endmodule // rfpg_lfsr

// ==== rfpg_top.v ====
// random per-reply parameter generator for simulated fruit replies
`timescale 1ns/1ns
`include "rfpg_defines.vh"

module rfpg_top (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // fruit environment parameter load from the controller
    input  wire        param_load,
    input  wire [4:0]  fixed_code_fraction_in,
    input  wire [11:0] fixed_code_in,
    // control word group request
    input  wire        group_req,
    // control word group
    output reg         group_valid,
    output reg  [5:0]  power_field,
    output reg         beam_select,
    output reg         sidelobe_atten_en,
    output reg  [10:0] angle_word,
    output reg         angle_sign,
    output reg  [11:0] reply_code,
    output reg  [15:0] reply_pulses,
    output reg         code_is_fixed
);

    // loaded environment parameters
    reg  [4:0]  fixed_code_fraction;
    reg  [11:0] fixed_code;

    // generator states
    wire [14:0] code_state;
    wire [6:0]  frac_state;
    wire [14:0] power_state;
    wire [10:0] angle_state;
    wire [16:0] beam_state;

    // lookup results
    reg  [5:0]  power_rom [0:511];
    wire [8:0]  power_addr;
    wire [5:0]  power_lookup;
    wire [5:0]  cd_bits;
    wire [10:0] monopulse_lookup;
    wire [11:0] random_code;
    wire        beam_bit;
    wire        select_fixed;
    reg  [11:0] next_code;
    reg  [15:0] next_pulses;

    // one generator per parameter except the angle sign, bit 14 of the power one; attenuation enable and power rom half both follow the beam bit
    rfpg_lfsr #(
        .WIDTH (`RFPG_CODE_LEN),
        .TAP   (`RFPG_CODE_TAP)
    ) u_code_lfsr (
        .sys_clk (sys_clk),
        .rst     (rst),
        .step    (group_req),
        .state   (code_state)
    );

    rfpg_lfsr #(
        .WIDTH (`RFPG_FRAC_LEN),
        .TAP   (`RFPG_FRAC_TAP)
    ) u_fraction_lfsr (
        .sys_clk (sys_clk),
        .rst     (rst),
        .step    (group_req),
        .state   (frac_state)
    );

    rfpg_lfsr #(
        .WIDTH (`RFPG_POWER_LEN),
        .TAP   (`RFPG_POWER_TAP)
    ) u_power_lfsr (
        .sys_clk (sys_clk),
        .rst     (rst),
        .step    (group_req),
        .state   (power_state)
    );

    rfpg_lfsr #(
        .WIDTH (`RFPG_ANGLE_LEN),
        .TAP   (`RFPG_ANGLE_TAP)
    ) u_angle_lfsr (
        .sys_clk (sys_clk),
        .rst     (rst),
        .step    (group_req),
        .state   (angle_state)
    );

    rfpg_lfsr #(
        .WIDTH (`RFPG_BEAM_LEN),
        .TAP   (`RFPG_BEAM_TAP)
    ) u_beam_lfsr (
        .sys_clk (sys_clk),
        .rst     (rst),
        .step    (group_req),
        .state   (beam_state)
    );

    rfpg_cd_rom u_cd_rom (
        .addr (code_state[14:6]),
        .cd   (cd_bits)
    );

    // entries per mainbeam attenuation step, half sums to 256
    function [5:0] main_count;
        input integer level;
        begin
            case (level)
                0:  main_count = 6'd0;
                1:  main_count = 6'd0;
                2:  main_count = 6'd0;
                3:  main_count = 6'd0;
                4:  main_count = 6'd0;
                5:  main_count = 6'd1;
                6:  main_count = 6'd1;
                7:  main_count = 6'd1;
                8:  main_count = 6'd1;
                9:  main_count = 6'd1;
                10: main_count = 6'd1;
                11: main_count = 6'd1;
                12: main_count = 6'd1;
                13: main_count = 6'd1;
                14: main_count = 6'd1;
                15: main_count = 6'd2;
                16: main_count = 6'd2;
                17: main_count = 6'd2;
                18: main_count = 6'd2;
                19: main_count = 6'd3;
                20: main_count = 6'd3;
                21: main_count = 6'd3;
                22: main_count = 6'd4;
                23: main_count = 6'd4;
                24: main_count = 6'd5;
                25: main_count = 6'd5;
                26: main_count = 6'd6;
                27: main_count = 6'd7;
                28: main_count = 6'd8;
                29: main_count = 6'd8;
                30: main_count = 6'd9;
                31: main_count = 6'd11;
                32: main_count = 6'd12;
                33: main_count = 6'd13;
                34: main_count = 6'd15;
                35: main_count = 6'd17;
                36: main_count = 6'd19;
                37: main_count = 6'd21;
                38: main_count = 6'd24;
                39: main_count = 6'd27;
                40: main_count = 6'd14;
                default: main_count = 6'd0;
            endcase
        end
    endfunction

    // entries per sidelobe step, on top of the switched attenuation
    function [5:0] side_count;
        input integer level;
        begin
            case (level)
                0:  side_count = 6'd0;
                1:  side_count = 6'd1;
                2:  side_count = 6'd1;
                3:  side_count = 6'd1;
                4:  side_count = 6'd2;
                5:  side_count = 6'd2;
                6:  side_count = 6'd2;
                7:  side_count = 6'd2;
                8:  side_count = 6'd2;
                9:  side_count = 6'd3;
                10: side_count = 6'd3;
                11: side_count = 6'd3;
                12: side_count = 6'd4;
                13: side_count = 6'd4;
                14: side_count = 6'd5;
                15: side_count = 6'd5;
                16: side_count = 6'd6;
                17: side_count = 6'd7;
                18: side_count = 6'd8;
                19: side_count = 6'd8;
                20: side_count = 6'd10;
                21: side_count = 6'd11;
                22: side_count = 6'd12;
                23: side_count = 6'd13;
                24: side_count = 6'd15;
                25: side_count = 6'd17;
                26: side_count = 6'd19;
                27: side_count = 6'd21;
                28: side_count = 6'd24;
                29: side_count = 6'd27;
                30: side_count = 6'd18;
                default: side_count = 6'd0;
            endcase
        end
    endfunction

    // rom image built once from the rounded counts
    integer lvl;
    integer rep;
    integer fill;
    initial begin
        fill = 0;
        for (lvl = 0; lvl < `RFPG_MAIN_LEVELS; lvl = lvl + 1) begin
            for (rep = 0; rep < main_count(lvl); rep = rep + 1) begin
                power_rom[fill] = lvl[5:0];
                fill = fill + 1;
            end
        end
        fill = `RFPG_HALF_DEPTH;
        for (lvl = 0; lvl < `RFPG_SIDE_LEVELS; lvl = lvl + 1) begin
            for (rep = 0; rep < side_count(lvl); rep = rep + 1) begin
                power_rom[fill] = lvl[5:0];
                fill = fill + 1;
            end
        end
    end

    assign beam_bit     = beam_state[0];
    assign power_addr   = {beam_bit, power_state[7:0]};
    assign power_lookup = power_rom[power_addr];

    // monopulse table kept as identity; a reshaped one drops in here
    assign monopulse_lookup = angle_state;

    assign random_code = {code_state[5:0], cd_bits};

    // fixed share is fraction/16; msb saturates anything above 16
    assign select_fixed = fixed_code_fraction[4] | (frac_state[3:0] < fixed_code_fraction[3:0]);

    always @* begin
        if (select_fixed) begin
            next_code = fixed_code;
        end else begin
            next_code = random_code;
        end
    end

    // pulse train in transmit order: f1 c1 a1 c2 a2 c4 a4 x b1 d1 b2 d2 b4 d4 f2 spi
    always @* begin
        next_pulses[15] = 1'b1;
        next_pulses[14] = next_code[3];
        next_pulses[13] = next_code[9];
        next_pulses[12] = next_code[4];
        next_pulses[11] = next_code[10];
        next_pulses[10] = next_code[5];
        next_pulses[9]  = next_code[11];
        next_pulses[8]  = 1'b0;
        next_pulses[7]  = next_code[6];
        next_pulses[6]  = next_code[0];
        next_pulses[5]  = next_code[7];
        next_pulses[4]  = next_code[1];
        next_pulses[3]  = next_code[8];
        next_pulses[2]  = next_code[2];
        next_pulses[1]  = 1'b1;
        next_pulses[0]  = 1'b0;
    end

    // environment parameters persist until the next load
    always @(posedge sys_clk) begin
        if (rst) begin
            fixed_code_fraction <= `RFPG_FRAC_RST;
            fixed_code          <= `RFPG_FIXED_RST;
        end else if (param_load) begin
            fixed_code_fraction <= fixed_code_fraction_in;
            fixed_code          <= fixed_code_in;
        end
    end

    // group sampled from the present states while generators step
    always @(posedge sys_clk) begin
        if (rst) begin
            group_valid       <= 1'b0;
            power_field       <= 6'h00;
            beam_select       <= 1'b0;
            sidelobe_atten_en <= 1'b0;
            angle_word        <= 11'h000;
            angle_sign        <= 1'b0;
            reply_code        <= 12'h000;
            reply_pulses      <= 16'h0000;
            code_is_fixed     <= 1'b0;
        end else begin
            group_valid <= group_req;
            if (group_req) begin
                power_field       <= power_lookup;
                beam_select       <= beam_bit;
                sidelobe_atten_en <= beam_bit;
                angle_word        <= monopulse_lookup;
                angle_sign        <= power_state[14];
                reply_code        <= next_code;
                code_is_fixed     <= select_fixed;
                reply_pulses      <= next_pulses;
            end
        end
    end

endmodule // rfpg_top
